//--- rtl/dmtc_pkg.sv
// Purpose: Shared constants for the debug monitor and trace control bank
// Assumes: 32-bit register port, byte-indexed addresses
// Notes:   Offsets are byte addresses on the plain register port
package dmtc_pkg;

  localparam int unsigned DMTC_AW = 4;
  localparam int unsigned DMTC_DW = 32;

  // Register offsets
  localparam logic [DMTC_AW-1:0] DMTC_OFF_CONTROL = 4'h0;  // debug_exception_monitor_control
  localparam logic [DMTC_AW-1:0] DMTC_OFF_STATUS  = 4'h4;  // block status
  localparam logic [DMTC_AW-1:0] DMTC_OFF_TRACE   = 4'h8;  // trace unit window

  // Field positions in the control register
  localparam int unsigned DMTC_BIT_TRACE_EN = 24;
  localparam int unsigned DMTC_BIT_MON_SEM  = 19;
  localparam int unsigned DMTC_BIT_MONITOR_SINGLE_STEP = 18;
  localparam int unsigned DMTC_BIT_MON_PEND = 17;
  localparam int unsigned DMTC_BIT_MONITOR_EXCEPTION_ENABLE   = 16;
  localparam int unsigned DMTC_MON_LSB      = 16;
  localparam int unsigned DMTC_MON_MSB      = 23;
  localparam int unsigned DMTC_HALT_MSB     = 15;

  // Writable bits: trace enable, monitor byte low bits, vector catch
  localparam logic [DMTC_DW-1:0] DMTC_WMASK_CTRL  = 32'h010f_07f1;
  // Bits that a local reset clears: the monitor field
  localparam logic [DMTC_DW-1:0] DMTC_LOCAL_CLR   = 32'h00ff_0000;
  localparam logic [DMTC_DW-1:0] DMTC_RESET_CTRL  = 32'h0000_0000;
  localparam logic [DMTC_DW-1:0] DMTC_RESET_TRACE = 32'h0000_0000;
  // Value read from a gated trace unit; stands for an unknown result
  localparam logic [DMTC_DW-1:0] DMTC_GATED_READ  = 32'h0000_0000;

  // Step request phases
  typedef enum logic [1:0] {
    DMTC_STEP_IDLE = 2'b00,
    DMTC_STEP_REQ  = 2'b01,
    DMTC_STEP_WAIT = 2'b10
  } dmtc_step_t;

endpackage : dmtc_pkg

//--- rtl/dmtc_trace_regs.sv
// Purpose: Small register store standing in for the trace unit registers
// Assumes: One clock, synchronous reset
// Notes:   Read data come out of a register
`timescale 1ns/10ps
module dmtc_trace_regs #(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0]      addr_i,
  input  wire logic [dmtc_pkg::DMTC_DW-1:0]  wr_data_i,
  output logic      [dmtc_pkg::DMTC_DW-1:0]  rd_data_o
);
  import dmtc_pkg::*;

  logic [DMTC_DW-1:0] mem [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= DMTC_RESET_TRACE;
      end
      rd_data_o <= DMTC_RESET_TRACE;
    end else begin
      if (wr_en_i) begin
        mem[addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[addr_i];
    end
  end

endmodule : dmtc_trace_regs

//--- rtl/dmtc_top.sv
// Purpose: Debug exception and monitor control register with trace gating
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   reset_i is the power-on reset; local_reset_i is the local reset
`timescale 1ns/10ps
module dmtc_top #(
  parameter bit          TRACE_PRESENT = 1'b1,
  parameter int unsigned TRACE_DEPTH   = 4
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          local_reset_i,
  input  wire logic [dmtc_pkg::DMTC_AW-1:0]  reg_addr_i,
  input  wire logic [dmtc_pkg::DMTC_DW-1:0]  reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic                          trace_sel_i,
  input  wire logic [1:0]                    trace_unit_i,
  input  wire logic                          step_done_i,
  output logic      [dmtc_pkg::DMTC_DW-1:0]  reg_rdata_o,
  output logic                               trace_enable_o,
  output logic                               monitor_enable_o,
  output logic                               monitor_step_req_o,
  output logic                               monitor_semaphore_o,
  output logic      [15:0]                   halt_ctrl_o
);
  import dmtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  localparam int unsigned TAW = $clog2(TRACE_DEPTH);

  typedef struct packed {
    logic [DMTC_DW-1:0] ctrl;
    logic [DMTC_DW-1:0] rdata;
    logic               tw_hit;
    logic [TAW-1:0]     tw_unit;
    logic [DMTC_DW-1:0] tw_data;
    logic               trace_en;
    logic               monitor_exception_enable;
    logic               step_req;
    logic               sem;
    logic [15:0]        halt;
    dmtc_step_t         step;
  } dmtc_state_t;

  dmtc_state_t st;
  dmtc_state_t next_st;

  logic [DMTC_DW-1:0] trace_rdata;
  logic               trace_wr;
  logic [TAW-1:0]     trace_addr;
  logic               unit_open;

  function automatic logic [DMTC_DW-1:0] dmtc_write_mask();
    logic [DMTC_DW-1:0] m;
    m = DMTC_WMASK_CTRL;
    if (!TRACE_PRESENT) begin
      m[DMTC_BIT_TRACE_EN] = 1'b0;
    end
    return m;
  endfunction : dmtc_write_mask

  ////////////////////////////////////////////////////////////////////////////
  // Trace unit window

  // Units 0 and 1 are the watchpoint and instrumentation units
  assign unit_open  = TRACE_PRESENT && st.ctrl[DMTC_BIT_TRACE_EN];
  assign trace_wr   = reg_wr_i && (reg_addr_i == DMTC_OFF_TRACE) && unit_open;
  assign trace_addr = TAW'(trace_unit_i);

  dmtc_trace_regs #(
    .DEPTH     (TRACE_DEPTH)
  ) u_trace (
    .core_clk_i(core_clk_i),
    .reset_i   (reset_i),
    .wr_en_i   (trace_wr),
    .addr_i    (trace_addr),
    .wr_data_i (reg_wdata_i),
    .rd_data_o (trace_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [DMTC_DW-1:0] wm;
    wm      = dmtc_write_mask();
    next_st = st;
    // Store read port lags a write by one cycle; bypass the last window write
    next_st.tw_hit  = trace_wr;
    next_st.tw_unit = trace_addr;
    next_st.tw_data = reg_wdata_i;

    // Register write
    if (reg_wr_i) begin
      if (reg_addr_i == DMTC_OFF_CONTROL) begin
        next_st.ctrl = (st.ctrl & ~wm) | (reg_wdata_i & wm);
      end
    end

    // Register read, data stand in the next cycle only
    next_st.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == DMTC_OFF_CONTROL) begin
        next_st.rdata = st.ctrl & wm;
      end else if (reg_addr_i == DMTC_OFF_STATUS) begin
        next_st.rdata = {28'h000_0000, st.step_req, unit_open, 2'(st.step)};
      end else if (reg_addr_i == DMTC_OFF_TRACE) begin
        if (!unit_open) begin
          next_st.rdata = DMTC_GATED_READ;
        end else if (st.tw_hit && st.tw_unit == trace_addr) begin
          next_st.rdata = st.tw_data;
        end else begin
          next_st.rdata = trace_rdata;
        end
      end else begin
        next_st.rdata = '0;
      end
    end

    // Monitor stepping, one step per request, like the halting step
    case (st.step)
      DMTC_STEP_IDLE: begin
        next_st.step_req = 1'b0;
        // Arm on the new value so a write that drops the enable cannot step
        if (next_st.ctrl[DMTC_BIT_MONITOR_SINGLE_STEP] && next_st.ctrl[DMTC_BIT_MONITOR_EXCEPTION_ENABLE]) begin
          next_st.step     = DMTC_STEP_REQ;
          next_st.step_req = 1'b1;
        end
      end
      DMTC_STEP_REQ: begin
        if (step_done_i || !st.ctrl[DMTC_BIT_MONITOR_EXCEPTION_ENABLE]) begin
          next_st.step     = DMTC_STEP_WAIT;
          next_st.step_req = 1'b0;
        end
      end
      DMTC_STEP_WAIT: begin
        // Rearm only once software drops the step bit or the enable
        if (!(st.ctrl[DMTC_BIT_MONITOR_SINGLE_STEP] && st.ctrl[DMTC_BIT_MONITOR_EXCEPTION_ENABLE])) begin
          next_st.step = DMTC_STEP_IDLE;
        end
      end
      default: begin
        next_st.step     = DMTC_STEP_IDLE;
        next_st.step_req = 1'b0;
      end
    endcase

    // Local reset: monitor field only; trace enable and halt bits kept
    if (local_reset_i) begin
      next_st.ctrl     = next_st.ctrl & ~DMTC_LOCAL_CLR;
      next_st.step     = DMTC_STEP_IDLE;
      next_st.step_req = 1'b0;
    end

    next_st.trace_en = next_st.ctrl[DMTC_BIT_TRACE_EN] && TRACE_PRESENT;
    next_st.monitor_exception_enable   = next_st.ctrl[DMTC_BIT_MONITOR_EXCEPTION_ENABLE];
    next_st.sem      = next_st.ctrl[DMTC_BIT_MON_SEM];
    next_st.halt     = next_st.ctrl[DMTC_HALT_MSB:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st       <= '0;
      st.ctrl  <= DMTC_RESET_CTRL;
      st.step  <= DMTC_STEP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o         = st.rdata;
  assign trace_enable_o      = st.trace_en;
  assign monitor_enable_o    = st.monitor_exception_enable;
  assign monitor_step_req_o  = st.step_req;
  assign monitor_semaphore_o = st.sem;
  assign halt_ctrl_o         = st.halt;

endmodule : dmtc_top

//--- testbench/dmtc_top_monitor.sv
// Purpose: Port assertions for dmtc_top
// Assumes: reset_i is the power-on reset
// Notes:   Bound into every dmtc_top
`timescale 1ns/10ps
module dmtc_top_monitor
  import dmtc_pkg::*;
#(
  parameter bit TRACE_PRESENT = 1'b1
) (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        local_reset_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        step_done_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        trace_enable_o,
  input wire logic        monitor_enable_o,
  input wire logic        monitor_step_req_o,
  input wire logic        monitor_semaphore_o,
  input wire logic [15:0] halt_ctrl_o
);
  logic [31:0] wd_q;
  always_ff @(posedge core_clk_i) wd_q <= reg_wdata_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  //////////////////////////////
  AST_POR_CLEAR: assert property (disable iff (1'b0) reset_i |=>
    !trace_enable_o && !monitor_enable_o && !monitor_semaphore_o && !monitor_step_req_o
    && halt_ctrl_o == 16'h0000) else $error("outputs not cleared by power-on reset");
  AST_LOCAL_CLEAR: assert property (local_reset_i |=>
    !monitor_enable_o && !monitor_semaphore_o && !monitor_step_req_o)
    else $error("monitor bits kept over local reset");
  AST_LOCAL_KEEP: assert property (local_reset_i && !reg_wr_i |=>
    $stable(trace_enable_o) && $stable(halt_ctrl_o)) else $error("local reset hit other bits");
  AST_STEP_GATE: assert property (!monitor_enable_o && $past(!monitor_enable_o) |->
    !monitor_step_req_o) else $error("step request without monitor enable");
  AST_STEP_RISE: assert property ($rose(monitor_step_req_o) |-> monitor_enable_o)
    else $error("step request rose while disabled");
  AST_STEP_DONE: assert property (monitor_step_req_o && step_done_i && !local_reset_i |=>
    !monitor_step_req_o [*2]) else $error("step request outlived its step");
  AST_GATED_READ: assert property (reg_rd_i && reg_addr_i == DMTC_OFF_TRACE
    && !trace_enable_o |=> reg_rdata_o == DMTC_GATED_READ) else $error("gated trace read");
  AST_CTRL_READ: assert property (reg_rd_i && reg_addr_i == DMTC_OFF_CONTROL |=>
    reg_rdata_o[24] == trace_enable_o && (reg_rdata_o & ~DMTC_WMASK_CTRL) == 32'h0000_0000)
    else $error("control read shows reserved bits");
  AST_WRITE_FIELDS: assert property (reg_wr_i && reg_addr_i == DMTC_OFF_CONTROL &&
    !local_reset_i |=> trace_enable_o == (wd_q[24] & TRACE_PRESENT)
    && monitor_semaphore_o == wd_q[19] && monitor_enable_o == wd_q[16]
    && halt_ctrl_o == (wd_q[15:0] & 16'h07f1)) else $error("control write fields wrong");
  COV_STEP: cover property ($rose(monitor_step_req_o));
  COV_GATED: cover property (reg_rd_i && reg_addr_i == DMTC_OFF_TRACE && !trace_enable_o);
  COV_LOCAL: cover property (local_reset_i && trace_enable_o);
endmodule : dmtc_top_monitor
bind dmtc_top dmtc_top_monitor #(.TRACE_PRESENT(TRACE_PRESENT)) u_mon (.*);

//--- testbench/dmtc_core_model.sv
// Purpose: Core answering monitor step requests
// Assumes: One done pulse per request
// Notes:   slow_i stretches the step to eleven cycles
`timescale 1ns/10ps
module dmtc_core_model (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic step_req_i,
  input  wire logic slow_i,
  output logic      step_done_o
);
  logic [3:0] wait_cnt;
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !step_req_i || step_done_o) begin
      wait_cnt <= 4'h0;
      step_done_o <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      step_done_o <= (wait_cnt == (slow_i ? 4'h9 : 4'h0));
    end
  end
endmodule : dmtc_core_model

//--- testbench/dmtc_top_tb.sv
// Purpose: Self-checking bench for dmtc_top
// Assumes: Gated trace reads stand as zero
// Notes:   trace_sel_i is a spare, tied low
`timescale 1ns/10ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, v); end end
module dmtc_top_tb;
  import dmtc_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        local_reset_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        trace_sel_i = 1'b0;
  logic [1:0]  trace_unit_i = 2'b00;
  logic        slow = 1'b0;
  logic        step_done_i, trace_enable_o, monitor_enable_o;
  logic        monitor_step_req_o, monitor_semaphore_o;
  logic [31:0] reg_rdata_o, rv;
  logic [15:0] halt_ctrl_o;
  logic        nt_trace_en;
  int          err_count = 0;
  int          compares = 0;
  int          n;
  always #5 core_clk_i = ~core_clk_i;
  dmtc_top dut (.*);
  // Second copy built without trace units
  dmtc_top #(.TRACE_PRESENT(1'b0)) dut_nt (
    .core_clk_i         (core_clk_i),
    .reset_i            (reset_i),
    .local_reset_i      (local_reset_i),
    .reg_addr_i         (reg_addr_i),
    .reg_wdata_i        (reg_wdata_i),
    .reg_wr_i           (reg_wr_i),
    .reg_rd_i           (reg_rd_i),
    .trace_sel_i        (trace_sel_i),
    .trace_unit_i       (trace_unit_i),
    .step_done_i        (1'b0),
    .reg_rdata_o        (),
    .trace_enable_o     (nt_trace_en),
    .monitor_enable_o   (),
    .monitor_step_req_o (),
    .monitor_semaphore_o(),
    .halt_ctrl_o        ()
  );
  dmtc_core_model core (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .step_req_i(monitor_step_req_o), .slow_i(slow), .step_done_o(step_done_i));
  //////////////////////////////
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    rv = reg_rdata_o;
  endtask : acc
  task automatic t_regs();
    acc(0, DMTC_OFF_CONTROL, 0);
    `CHK("ctrl at reset", 32'h0000_0000, rv)
    acc(0, 4'hc, 0);
    `CHK("unmapped", 32'h0000_0000, rv)
    acc(1, DMTC_OFF_CONTROL, 32'hffff_ffff);
    `CHK("halt field", 16'h07f1, halt_ctrl_o)
    `CHK("semaphore", 1'b1, monitor_semaphore_o)
    acc(0, DMTC_OFF_CONTROL, 0);
    `CHK("ctrl masked", DMTC_WMASK_CTRL, rv)
    @(posedge core_clk_i);
    local_reset_i <= 1'b1;
    @(posedge core_clk_i);
    local_reset_i <= 1'b0;
    acc(0, DMTC_OFF_CONTROL, 0);
    `CHK("after local reset", 32'h0100_07f1, rv)
  endtask : t_regs
  task automatic t_trace();
    for (int u = 0; u < 2; u++) begin
      trace_unit_i <= u[1:0];
      acc(1, DMTC_OFF_CONTROL, 32'h0100_0000);
      `CHK("no trace units", 1'b0, nt_trace_en)
      acc(1, DMTC_OFF_TRACE, 32'h5a5a_0001 + u);
      acc(0, DMTC_OFF_TRACE, 0);
      `CHK("trace open", 32'h5a5a_0001 + u, rv)
      acc(1, DMTC_OFF_TRACE, 0);
      acc(1, DMTC_OFF_CONTROL, 0);
      acc(1, DMTC_OFF_TRACE, 32'h1234_5678);
      acc(0, DMTC_OFF_TRACE, 0);
      `CHK("gated read", DMTC_GATED_READ, rv)
      acc(1, DMTC_OFF_CONTROL, 32'h0100_0000);
      acc(0, DMTC_OFF_TRACE, 0);
      `CHK("gated write dropped", 32'h0000_0000, rv)
    end
  endtask : t_trace
  task automatic t_step();
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      acc(1, DMTC_OFF_CONTROL, 0);
      acc(1, DMTC_OFF_CONTROL, 32'h0005_0000);
      for (n = 0; monitor_step_req_o !== 1'b1 && n < 20; n++) @(posedge core_clk_i);
      `CHK("step request", 1'b1, monitor_step_req_o)
      for (n = 0; monitor_step_req_o === 1'b1 && n < 40; n++) @(posedge core_clk_i);
      `CHK("step held for core", (s == 1), (n > 5))
      repeat (4) @(posedge core_clk_i);
      `CHK("one step per request", 1'b0, monitor_step_req_o)
    end
    acc(1, DMTC_OFF_CONTROL, 32'h0004_0000);
    repeat (4) @(posedge core_clk_i);
    `CHK("step without enable", 1'b0, monitor_step_req_o)
  endtask : t_step
  task automatic close_out();
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_trace();
    t_step();
    close_out();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_i);
    err_count++;
    close_out();
  end
endmodule : dmtc_top_tb
